// ---- hdl/i2c_byte_master.sv ----
// What this block does
// R1 - transmit-execute starts one byte, after any start or byte in progress ends
// R2 - loading shift register clears transmit-execute and raises transmit-empty cause
// R3 - transmit bits change at serial clock falling edge, MSB first
// R4 - nine clocks per byte; SDA released in ninth to read acknowledge
// R5 - acknowledge bit records 0 when slave pulls SDA low, else 1
// R6 - transmit busy set at byte start, cleared at end or wait
// R7 - software sends START and address with read direction before receiving
// R8 - receive-execute requests one byte; transmit wins when both set
// R9 - receive releases SDA and samples at rising edge, MSB first
// R10 - receive-execute clears itself while sampling data bit 6
// R11 - received byte loads data, sets ready; read clears; newer overwrites
// R12 - receive busy set at reception start, cleared at end or wait
// R13 - ninth clock of receive drives acknowledge bit: 0 ack, 1 nack
// R14 - stop request raises SDA while SCL high, freeing the bus
// R15 - stop waits for byte and acknowledge; stop request then self-clears
// R16 - no repeated start; software issues STOP before a new START
// R17 - nothing pending at byte end holds SCL low until new request
// R18 - software disables only when both busy flags read zero
// R19 - start request pulls SDA low while SCL high, then self-clears
// R20 - software puts address in upper bits, direction in bit 0
// R21 - interrupt pulse per cause only when its enable is set
// R22 - SDA and SCL are open drain: pull low or release
`timescale 1ns/1ps
module i2c_byte_master
  import i2c_byte_pkg::*;
(
  input  wire logic                            clk,         // 125 MHz system clock
  input  wire logic                            reset,       // synchronous, active high
  input  wire logic [i2c_byte_pkg::ADDR_W-1:0] address,     // byte address
  input  wire logic                            read,        // read request
  input  wire logic                            write,       // write request
  input  wire logic [i2c_byte_pkg::DATA_W-1:0] writedata,   // write data
  input  wire logic [3:0]                      byteenable,  // byte lanes
  output logic      [i2c_byte_pkg::DATA_W-1:0] readdata,    // read data
  output logic                                 waitrequest, // stall the master
  input  wire logic                            serial_clk,  // timer clock for SCL
  input  wire logic                            sda_in,      // SDA line level
  output logic                                 sda_out,     // SDA drive value
  output logic                                 sda_oe_n,    // low while pulling SDA
  input  wire logic                            scl_in,      // SCL line level
  output logic                                 scl_out,     // SCL drive value
  output logic                                 scl_oe_n,    // low while pulling SCL
  output logic                                 irq          // one-cycle request pulse
);
  import i2c_byte_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic        enable;
    logic        start_request;
    logic        stop_request;
    logic        noise_remove;
    logic        transmit_execute;
    logic        receive_execute;
    logic        acknowledge_bit;
    logic [7:0]  byte_field;
    logic        receive_ready_flag;
    logic        tx_empty_irq_enable;
    logic        rx_full_irq_enable;
    logic        transmit_busy_flag;
    logic        receive_busy_flag;
    phase_t      phase;
    logic [3:0]  slot;
    logic [7:0]  shifter;
    logic        receiving;
    logic        sda_low;
    logic        scl_low;
    logic        tclk_d;
    logic        bus_ack;
    logic [31:0] rdata;
    logic        irq;
  } state_t;

  state_t r;
  state_t n;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // all three pins share one two-stage synchroniser
  sync_if #(.W(SYN_W)) pins ();

  assign pins.raw[SYN_TCLK] = serial_clk;
  assign pins.raw[SYN_SDA]  = sda_in;
  assign pins.raw[SYN_SCL]  = scl_in;

  sync_two_ff #(.W(SYN_W)) u_sync (
    .clk   (clk),
    .reset (reset),
    .lanes (pins)
  );

  logic tclk_s;
  logic sda_s;
  logic scl_s;
  logic tclk_rise;
  logic tclk_fall;

  assign tclk_s    = pins.synced[SYN_TCLK];
  assign sda_s     = pins.synced[SYN_SDA];
  assign scl_s     = pins.synced[SYN_SCL];
  // serial edges lag the pin by the synchroniser depth, two cycles
  assign tclk_rise = tclk_s & ~r.tclk_d;
  assign tclk_fall = ~tclk_s & r.tclk_d;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        req;
  logic        rd_sample;
  logic        wr_take;
  logic        hit_en;
  logic        hit_ctl;
  logic        hit_dat;
  logic        hit_ictl;
  logic [15:0] wmask;
  logic [15:0] wval;

  assign req       = read | write;
  // read side effects happen when the data is captured, so the cleared
  // flag always belongs to the value the master receives
  assign rd_sample = read & ~r.bus_ack;
  assign wr_take   = write & r.bus_ack;
  assign hit_en    = (address == {IDX_ENABLE, 2'b00});
  assign hit_ctl   = (address == {IDX_CTL, 2'b00});
  assign hit_dat   = (address == {IDX_DAT, 2'b00});
  assign hit_ictl  = (address == {IDX_ICTL, 2'b00});
  // only the low half carries register bits; lanes 2 and 3 are ignored
  assign wmask     = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wval      = writedata[15:0];

  function automatic logic merge(input logic old, input int pos,
                                 input logic [15:0] m, input logic [15:0] v);
    merge = m[pos] ? v[pos] : old;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n        = r;
    n.irq    = 1'b0;
    n.tclk_d = tclk_s;

    // register reads
    n.bus_ack = req & ~r.bus_ack;
    if (rd_sample) begin
      n.rdata = '0;
      if (hit_en) begin
        n.rdata[EN_BIT] = r.enable;
      end else if (hit_ctl) begin
        n.rdata[CTL_START] = r.start_request;
        n.rdata[CTL_STOP]  = r.stop_request;
        n.rdata[CTL_NOISE] = r.noise_remove;
        n.rdata[CTL_TRANSMIT_BUSY_FLAG] = r.transmit_busy_flag;
        n.rdata[CTL_RECEIVE_BUSY_FLAG] = r.receive_busy_flag;
      end else if (hit_dat) begin
        n.rdata[7:0]       = r.byte_field;
        n.rdata[DAT_ACK]   = r.acknowledge_bit;
        n.rdata[DAT_TXE]   = r.transmit_execute;
        n.rdata[DAT_RXE]   = r.receive_execute;
        n.rdata[DAT_RECEIVE_READY_FLAG] = r.receive_ready_flag;
        n.receive_ready_flag = 1'b0; // R11
      end else if (hit_ictl) begin
        n.rdata[ICTL_TIEN] = r.tx_empty_irq_enable;
        n.rdata[ICTL_RIEN] = r.rx_full_irq_enable;
      end else begin
        n.rdata = '0;
      end
    end

    // serial engine; hardware clears are overridden by a same-cycle write
    case (r.phase)
      ST_IDLE: begin
        n.sda_low = 1'b0;
        n.scl_low = 1'b0;
        // a start only from idle, so a repeated start cannot happen
        if (r.start_request && tclk_s && scl_s) begin // R16
          n.sda_low       = 1'b1; // R19
          n.start_request = 1'b0; // R19
          n.phase         = ST_START_LOW;
        end
      end
      ST_START_LOW: begin
        if (tclk_fall) begin
          n.scl_low = 1'b1;
          n.phase   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // scl stays low until something is queued
        n.scl_low = 1'b1; // R17
        if (r.transmit_execute) begin // R1 R8
          n.shifter            = r.byte_field;
          n.transmit_execute   = 1'b0; // R2
          n.irq                = r.tx_empty_irq_enable; // R2 R21
          n.transmit_busy_flag = 1'b1; // R6
          n.receiving          = 1'b0;
          n.slot               = '0;
          n.sda_low            = ~r.byte_field[7]; // R3
          n.phase              = ST_XFER;
        end else if (r.receive_execute) begin
          n.receive_busy_flag = 1'b1; // R12
          n.receiving         = 1'b1;
          n.slot              = '0;
          // sda stays released so the slave can drive the first bit
          n.sda_low           = 1'b0; // R9
          n.phase             = ST_XFER;
        end else if (r.stop_request) begin
          n.phase = ST_STOP_LOW; // R15
        end
      end
      ST_XFER: begin
        if (tclk_rise) begin
          n.scl_low = 1'b0;
          // the ack slot of a receive is driven by us, never sampled
          if (r.receiving && r.slot != ACK_SLOT) begin
            n.shifter = {r.shifter[6:0], sda_s}; // R9
            if (r.slot == RX_D6_SLOT) begin
              n.receive_execute = 1'b0; // R10
            end
          end else if (!r.receiving && r.slot == ACK_SLOT) begin
            n.acknowledge_bit = sda_s; // R5
          end
        end else if (tclk_fall) begin
          n.scl_low = 1'b1;
          if (r.slot == ACK_SLOT) begin
            // byte and acknowledge done
            n.sda_low            = 1'b0;
            n.transmit_busy_flag = 1'b0; // R6
            n.receive_busy_flag  = 1'b0; // R12
            if (r.receiving) begin
              n.byte_field         = r.shifter; // R11
              n.receive_ready_flag = 1'b1; // R11
              n.irq                = r.rx_full_irq_enable; // R21
            end
            n.phase = ST_HOLD; // R17
          end else begin
            n.slot = r.slot + 4'h1;
            if (r.slot + 4'h1 == ACK_SLOT) begin
              // receive drives the ack, transmit lets the slave answer
              n.sda_low = r.receiving ? ~r.acknowledge_bit : 1'b0; // R4 R13
            end else if (!r.receiving) begin
              n.shifter = {r.shifter[6:0], 1'b0};
              n.sda_low = ~r.shifter[6]; // R3
            end
          end
        end
      end
      ST_STOP_LOW: begin
        // sda is pulled while scl is still low, so its later rise is the stop
        if (tclk_fall) begin
          n.sda_low = 1'b1;
          n.phase   = ST_STOP_HIGH;
        end
      end
      ST_STOP_HIGH: begin
        // scl goes first; sda follows half a serial period later
        if (tclk_rise) begin
          n.scl_low = 1'b0;
          n.phase   = ST_STOP_FREE;
        end
      end
      ST_STOP_FREE: begin
        // scl must really be high before sda rises
        if (tclk_fall && scl_s) begin
          n.sda_low      = 1'b0; // R14
          n.stop_request = 1'b0; // R15
          n.phase        = ST_IDLE;
        end
      end
      default: begin
        n.phase = ST_IDLE;
      end
    endcase

    // disabling mid-byte abandons it; only phase, pins, busy flags and irq are cleared
    if (!r.enable) begin
      n.phase              = ST_IDLE;
      n.sda_low            = 1'b0;
      n.scl_low            = 1'b0;
      n.transmit_busy_flag = 1'b0;
      n.receive_busy_flag  = 1'b0;
      n.irq                = 1'b0;
    end

    // register writes
    // reserved bits are dropped here and read back as zero
    if (wr_take) begin
      if (hit_en) begin
        n.enable = merge(r.enable, EN_BIT, wmask, wval);
      end else if (hit_ctl) begin
        n.start_request = merge(n.start_request, CTL_START, wmask, wval);
        n.stop_request  = merge(n.stop_request, CTL_STOP, wmask, wval);
        n.noise_remove  = merge(r.noise_remove, CTL_NOISE, wmask, wval);
      end else if (hit_dat) begin
        // a received byte landing this cycle beats the software write
        if (byteenable[0] && !(r.phase == ST_XFER && r.receiving && tclk_fall
                               && r.slot == ACK_SLOT)) begin
          n.byte_field = wval[7:0];
        end
        n.transmit_execute = merge(n.transmit_execute, DAT_TXE, wmask, wval);
        n.receive_execute  = merge(n.receive_execute, DAT_RXE, wmask, wval);
        // likewise the slave's answer beats a write to the ack bit
        if (!(r.phase == ST_XFER && !r.receiving && tclk_rise
              && r.slot == ACK_SLOT)) begin
          n.acknowledge_bit = merge(r.acknowledge_bit, DAT_ACK, wmask, wval);
        end
      end else if (hit_ictl) begin
        n.tx_empty_irq_enable = merge(r.tx_empty_irq_enable, ICTL_TIEN, wmask, wval);
        n.rx_full_irq_enable  = merge(r.rx_full_irq_enable, ICTL_RIEN, wmask, wval);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (reset) begin
      r            <= '0;
      r.phase      <= ST_IDLE;
      r.byte_field <= BYTE_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign readdata    = r.rdata;
  // one wait state per access, as the read data come from a register
  assign waitrequest = req & ~r.bus_ack;
  assign irq         = r.irq;
  // the pins only ever pull low; the high level comes from the pull-ups
  assign sda_out     = 1'b0; // R22
  assign scl_out     = 1'b0; // R22
  assign sda_oe_n    = ~r.sda_low; // R22
  assign scl_oe_n    = ~r.scl_low; // R22

endmodule : i2c_byte_master

// ---- hdl/i2c_byte_pkg.sv ----
package i2c_byte_pkg;

  // bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ENABLE = 16'h4340;
  localparam logic [15:0] IDX_CTL    = 16'h4342;
  localparam logic [15:0] IDX_DAT    = 16'h4344;
  localparam logic [15:0] IDX_ICTL   = 16'h4346;

  // enable register
  localparam int EN_BIT     = 0;
  // bus_control_status fields
  localparam int CTL_START  = 0;
  localparam int CTL_STOP   = 1;
  localparam int CTL_NOISE  = 4;
  localparam int CTL_TRANSMIT_BUSY_FLAG  = 8;
  localparam int CTL_RECEIVE_BUSY_FLAG  = 9;
  // byte_data_and_command fields
  localparam int DAT_ACK    = 8;
  localparam int DAT_TXE    = 9;
  localparam int DAT_RXE    = 10;
  localparam int DAT_RECEIVE_READY_FLAG  = 11;
  // interrupt enable register
  localparam int ICTL_TIEN  = 0;
  localparam int ICTL_RIEN  = 1;

  // bit slots of one byte: 0..7 data, 8 acknowledge
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [3:0] RX_D6_SLOT = 4'h1;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  // synchroniser lanes
  localparam int SYN_TCLK = 0;
  localparam int SYN_SDA  = 1;
  localparam int SYN_SCL  = 2;
  localparam int SYN_W    = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_LOW,
    ST_HOLD,
    ST_XFER,
    ST_STOP_LOW,
    ST_STOP_HIGH,
    ST_STOP_FREE
  } phase_t;

endpackage : i2c_byte_pkg

// ---- hdl/sync_if.sv ----
`timescale 1ns/1ps
interface sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : sync_if

// ---- hdl/sync_two_ff.sv ----
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int W = 1
) (
  input wire logic clk,     // system clock
  input wire logic reset,   // synchronous, active high
  sync_if.dst      lanes    // raw in, synced out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  // first stage feeds only the second stage
  always_comb begin
    n    = r;
    n.s1 = lanes.raw;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lanes.synced = r.s2;
endmodule : sync_two_ff

// ---- sim/i2c_byte_master_chk.sv ----
`timescale 1ns/1ps
module i2c_byte_master_chk
  import i2c_byte_pkg::*;
(
  input wire logic              clk,         // system clock
  input wire logic              reset,       // sync reset
  input wire logic [ADDR_W-1:0] address,     // byte address
  input wire logic              read,        // read request
  input wire logic              write,       // write request
  input wire logic [DATA_W-1:0] writedata,   // write data
  input wire logic [3:0]        byteenable,  // lanes
  input wire logic [DATA_W-1:0] readdata,    // read data
  input wire logic              waitrequest, // stall
  input wire logic              serial_clk,  // timer clock
  input wire logic              sda_in,      // SDA level
  input wire logic              sda_out,     // SDA value
  input wire logic              sda_oe_n,    // SDA pull
  input wire logic              scl_in,      // SCL level
  input wire logic              scl_out,     // SCL value
  input wire logic              scl_oe_n,    // SCL pull
  input wire logic              irq          // request pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] low_cnt_r;
  logic       wr_seen_r;
  // long SCL low with no write since it fell can only be the wait state
  always_ff @(posedge clk) begin
    if (reset || scl_oe_n) begin
      low_cnt_r <= 8'h00;
      wr_seen_r <= 1'b0;
    end else begin
      if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
      if (write) wr_seen_r <= 1'b1;
    end
  end
  ////////////////////////////////////////
  sequence start_edge;
    $fell(sda_oe_n) && scl_oe_n && scl_in;
  endsequence
  sequence stop_edge;
    $rose(sda_oe_n) && scl_oe_n;
  endsequence
  irq_pulse_a: assert property (irq |=> !irq)
    else $error("irq wider than one cycle");
  open_drain_a: assert property (!sda_out && !scl_out)
    else $error("line driven high");
  start_bound_a: assert property (start_edge |-> ##[1:24] !scl_oe_n)
    else $error("SCL not pulled after start");
  start_hold_a: assert property (start_edge |=> !sda_oe_n until !scl_oe_n)
    else $error("SDA released before SCL pulled");
  stop_setup_a: assert property (stop_edge |-> $past(scl_oe_n))
    else $error("SDA rose before SCL was high");
  stop_free_a: assert property (stop_edge |=> (sda_oe_n && scl_oe_n)[*8])
    else $error("bus not left free after stop");
  scl_rise_a: assert property ($rose(scl_oe_n) |-> serial_clk)
    else $error("SCL released in serial low phase");
  scl_fall_a: assert property ($fell(scl_oe_n) |-> !serial_clk)
    else $error("SCL pulled in serial high phase");
  wait_hold_a: assert property (low_cnt_r >= 8'h10 && !wr_seen_r |=> !scl_oe_n)
    else $error("SCL left wait state without a write");
  bus_wait_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule : i2c_byte_master_chk

bind i2c_byte_master i2c_byte_master_chk chk (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .serial_clk(serial_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .irq(irq)
);

// ---- sim/i2c_slave_model.sv ----
`timescale 1ns/1ps
module i2c_slave_model (
  input  wire logic       scl,      // bus clock level
  input  wire logic       sda,      // bus data level
  input  wire logic       ack_en,   // 0 refuses written bytes
  input  wire logic [7:0] tx_byte,  // byte returned on reads
  output logic            sda_pull, // 1 while pulling SDA low
  output logic [7:0]      rx_byte,  // last byte taken
  output logic            m_ack     // master acknowledge seen
);
  int         cnt = 10;
  logic       rd  = 1'b0;
  logic       adr = 1'b0;
  logic [7:0] sh  = 8'h00;
  initial begin
    sda_pull = 1'b0;
    rx_byte  = 8'h00;
    m_ack    = 1'b1;
  end
  ////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    cnt = 0;
    rd  = 1'b0;
    adr = 1'b1;
  end
  always @(posedge sda) if (scl) begin
    cnt = 10;
    rd  = 1'b0;
    sda_pull <= 1'b0;
  end
  always @(posedge scl) begin
    if (!rd && cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
    end
    if (rd && cnt == 9) begin
      m_ack = sda;
      // a refused byte ends the read so the master can stop
      if (sda) rd = 1'b0;
    end
  end
  always @(negedge scl) begin
    if (cnt == 8) begin
      if (!rd) rx_byte = sh;
      sda_pull <= !rd && ack_en;
      cnt = 9;
    end else if (cnt == 9) begin
      sda_pull <= 1'b0;
      cnt = 0;
      if (adr) rd = sh[0];
      adr = 1'b0;
    end
    if (rd && cnt < 8) begin
      sda_pull <= ~tx_byte[7 - cnt];
      cnt++;
    end
  end
endmodule : i2c_slave_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import i2c_byte_pkg::*;
  typedef struct packed {
    logic [15:0] idx;
    logic [15:0] wd;
    logic [15:0] rd;
  } row_t;
  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic              serial_clk;
  logic              sda_oe_n;
  logic              scl_oe_n;
  logic              irq;
  logic              sda_pull;
  logic              ack_en;
  logic [7:0]        rx_byte;
  logic              m_ack;
  logic [15:0]       v;
  wire               sda;
  int                error_cnt = 0;
  int                checks = 0;
  int                irq_n = 0;
  int                cyc = 0;
  logic [15:0]       idxs [4] = '{IDX_ENABLE, IDX_CTL, IDX_DAT, IDX_ICTL};
  row_t              rows [5] = '{
    '{IDX_ENABLE, 16'h0001, 16'h0001},
    '{IDX_ICTL,   16'h0003, 16'h0003},
    '{IDX_CTL,    16'h0310, 16'h0010},
    '{IDX_DAT,    16'h01A5, 16'h01A5},
    '{16'h4348,   16'h1234, 16'h0000}
  };
  // late by 1 ns so a bit change at an SCL fall never looks like start or stop
  assign #1 sda = sda_oe_n & ~sda_pull;
  i2c_byte_master dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .serial_clk(serial_clk), .sda_in(sda),
    .sda_out(), .sda_oe_n(sda_oe_n), .scl_in(scl_oe_n), .scl_out(),
    .scl_oe_n(scl_oe_n), .irq(irq)
  );
  i2c_slave_model slave (
    .scl(scl_oe_n), .sda(sda), .ack_en(ack_en), .tx_byte(8'hC3),
    .sda_pull(sda_pull), .rx_byte(rx_byte), .m_ack(m_ack)
  );
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    serial_clk = 1'b0;
    #3;
    forever #40 serial_clk = ~serial_clk;
  end
  // the one-cycle pulse is counted at the falling edge, where it stands settled
  always @(negedge clk) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] d);
    logic done;
    address   <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    write     <= wr;
    read      <= ~wr;
    done = 1'b0;
    // waitrequest is judged settled before the edge, not in the edge's own time step
    while (!done) begin
      @(negedge clk);
      done = (waitrequest === 1'b0);
      @(posedge clk);
    end
    v = readdata[15:0];
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic poll(input logic [15:0] idx, input logic [15:0] m, input logic [15:0] e);
    do bus(1'b0, idx, 16'h0000); while ((v & m) !== e);
  endtask : poll
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    ack_en = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (idxs[i]) begin
      bus(1'b0, idxs[i], 16'h0000);
      check(v, 16'h0000);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      bus(1'b0, rows[i].idx, 16'h0000);
      check(v, rows[i].rd);
    end
    $display("test registers done");
    bus(1'b1, IDX_DAT, 16'h02A4);
    bus(1'b1, IDX_CTL, 16'h0001);
    poll(IDX_CTL, 16'h0100, 16'h0100);
    bus(1'b0, IDX_DAT, 16'h0000);
    check(v & 16'h0200, 16'h0000);
    poll(IDX_CTL, 16'h0100, 16'h0000);
    bus(1'b0, IDX_DAT, 16'h0000);
    check(v, 16'h00A4);
    check({8'h00, rx_byte}, 16'h00A4);
    check(16'(irq_n), 16'h0001);
    $display("test write ack done");
    ack_en <= 1'b0;
    bus(1'b1, IDX_DAT, 16'h0255);
    poll(IDX_CTL, 16'h0100, 16'h0100);
    bus(1'b1, IDX_CTL, 16'h0002);
    poll(IDX_CTL, 16'h0302, 16'h0000);
    bus(1'b0, IDX_DAT, 16'h0000);
    check(v, 16'h0155);
    check({8'h00, rx_byte}, 16'h0055);
    check({14'h0000, sda, scl_oe_n}, 16'h0003);
    $display("test preset stop done");
    ack_en <= 1'b1;
    bus(1'b1, IDX_ICTL, 16'h0002);
    bus(1'b1, IDX_DAT, 16'h06A5);
    bus(1'b1, IDX_CTL, 16'h0001);
    poll(IDX_CTL, 16'h0200, 16'h0200);
    poll(IDX_DAT, 16'h0800, 16'h0800);
    check(v, 16'h08C3);
    bus(1'b0, IDX_DAT, 16'h0000);
    check(v, 16'h00C3);
    check({15'h0000, m_ack}, 16'h0000);
    check(16'(irq_n), 16'h0003);
    bus(1'b0, IDX_CTL, 16'h0000);
    check(v & 16'h0300, 16'h0000);
    $display("test read done");
    bus(1'b1, IDX_CTL, 16'h0002);
    poll(IDX_CTL, 16'h0302, 16'h0000);
    check({14'h0000, sda, scl_oe_n}, 16'h0003);
    bus(1'b1, IDX_ENABLE, 16'h0000);
    bus(1'b0, IDX_ENABLE, 16'h0000);
    check(v, 16'h0000);
    $display("test stop and disable done");
    end_of_test();
  end
endmodule : testbench
